//--- hw/cpd_pkg.sv
// Constants, types and mode decode for the command pulse input decoder
`default_nettype none

package cpd_pkg;

  // --------------------------------------------------------------------
  // Mode setting
  // --------------------------------------------------------------------
  localparam int         MODE_W   = 4;
  localparam logic [3:0] MODE_MAX = 4'h9;
  localparam logic [3:0] NEG_BASE = 4'h5;
  localparam logic [3:0] MODE_RST = 4'h0;

  // --------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------
  localparam int CLK_HZ       = 50_000_000;
  localparam int CLEAR_MIN_US = 20;
  // Least time, so round up to whole cycles
  localparam int CLEAR_CYC    =
    (CLEAR_MIN_US * CLK_HZ + 999_999) / 1_000_000;
  localparam int CLR_W        = $clog2(CLEAR_CYC + 1);

  // --------------------------------------------------------------------
  // Counter defaults
  // --------------------------------------------------------------------
  localparam int CNT_W_DEF = 16;

  // --------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    FMT_PD,
    FMT_SEP,
    FMT_QX1,
    FMT_QX2,
    FMT_QX4
  } cpd_fmt_t;

  typedef struct packed {
    cpd_fmt_t fmt;
    logic     neg;
    logic     valid;
  } cpd_mode_t;

  typedef struct packed {
    logic clr;
    logic b;
    logic a;
  } cpd_pins_t;

  function automatic cpd_mode_t mode_decode(input logic [3:0] sel);
    cpd_mode_t m;
    logic [3:0] base;
    m.valid = (sel <= MODE_MAX);
    m.neg   = (sel >= NEG_BASE) && m.valid;
    base    = m.neg ? sel - NEG_BASE : sel;
    case (base)
      4'h0:    m.fmt = FMT_PD;
      4'h1:    m.fmt = FMT_SEP;
      4'h2:    m.fmt = FMT_QX1;
      4'h3:    m.fmt = FMT_QX2;
      4'h4:    m.fmt = FMT_QX4;
      default: m.fmt = FMT_PD;
    endcase
    return m;
  endfunction : mode_decode

endpackage : cpd_pkg

`default_nettype wire

//--- hw/cpd_sync.sv
// Two-flop synchroniser for the asynchronous command pins
`default_nettype none

module cpd_sync #(
  parameter int W = 3
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         arst_n,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] hold_r;
  logic [W-1:0] hold_nxt;

  // Only the second stage is read outside
  always_comb begin
    meta_nxt = d;
    hold_nxt = meta_r;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= '0;
      hold_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      hold_r <= hold_nxt;
    end
  end

  assign q = hold_r;

endmodule : cpd_sync

`default_nettype wire

//--- hw/cpd_decoder.sv
// Command pulse input decoder: format select, step decode, clear filter
`default_nettype none

module cpd_decoder #(
  parameter int CNT_W = cpd_pkg::CNT_W_DEF
) (
  // Clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      arst_n,
  // Command pins, asynchronous
  input  wire logic                      cmd_a_in,
  input  wire logic                      cmd_b_in,
  input  wire logic                      deviation_clear_in,
  // Configuration, same clock
  input  wire logic [cpd_pkg::MODE_W-1:0] command_pulse_mode_select,
  // Position loop side
  output logic                           step_fwd,
  output logic                           step_rev,
  output logic      [CNT_W-1:0]          cmd_count,
  output logic                           clear_active,
  output logic                           mode_err
);

  // ----------------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------------
  if (CNT_W < 2 || CNT_W > 32) begin : g_bad_cnt_w
    $error("CNT_W must lie in 2..32");
  end

  // ----------------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------------
  cpd_pkg::cpd_pins_t pins_raw;
  cpd_pkg::cpd_pins_t pins_s;

  assign pins_raw.clr = deviation_clear_in;
  assign pins_raw.b   = cmd_b_in;
  assign pins_raw.a   = cmd_a_in;

  cpd_sync #(
    .W ($bits(cpd_pkg::cpd_pins_t))
  ) u_sync (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .d       (pins_raw),
    .q       (pins_s)
  );

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [cpd_pkg::MODE_W-1:0] mode_r;
  logic [cpd_pkg::MODE_W-1:0] mode_nxt;
  logic                       a_prev_r;
  logic                       a_prev_nxt;
  logic                       b_prev_r;
  logic                       b_prev_nxt;
  logic                       step_fwd_r;
  logic                       step_fwd_nxt;
  logic                       step_rev_r;
  logic                       step_rev_nxt;
  logic [CNT_W-1:0]           cmd_count_r;
  logic [CNT_W-1:0]           cmd_count_nxt;
  logic [cpd_pkg::CLR_W-1:0]  clr_cnt_r;
  logic [cpd_pkg::CLR_W-1:0]  clr_cnt_nxt;
  logic                       clear_active_r;
  logic                       clear_active_nxt;
  logic                       mode_err_r;
  logic                       mode_err_nxt;
  logic [2:0]                 live_r;
  logic [2:0]                 live_nxt;

  cpd_pkg::cpd_mode_t mode;
  logic               a_eff;
  logic               b_eff;
  logic               a_peff;
  logic               b_peff;
  logic               a_rise;
  logic               a_fall;
  logic               b_rise;
  logic               b_fall;
  logic               fwd;
  logic               rev;

  localparam logic [cpd_pkg::CLR_W-1:0] CLR_LAST =
    cpd_pkg::CLR_W'(cpd_pkg::CLEAR_CYC - 1);
  localparam logic [cpd_pkg::CLR_W-1:0] CLR_FULL =
    cpd_pkg::CLR_W'(cpd_pkg::CLEAR_CYC);

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  always_comb begin
    mode     = cpd_pkg::mode_decode(mode_r);
    // Previous levels are kept raw so a mode change makes no false edge
    a_eff    = pins_s.a ^ mode.neg;
    b_eff    = pins_s.b ^ mode.neg;
    a_peff   = a_prev_r ^ mode.neg;
    b_peff   = b_prev_r ^ mode.neg;
    a_rise   = a_eff & ~a_peff;
    a_fall   = ~a_eff & a_peff;
    b_rise   = b_eff & ~b_peff;
    b_fall   = ~b_eff & b_peff;
    fwd      = 1'b0;
    rev      = 1'b0;
    case (mode.fmt)
      cpd_pkg::FMT_PD: begin
        fwd = a_rise & b_eff;
        rev = a_rise & ~b_eff;
      end
      cpd_pkg::FMT_SEP: begin
        rev = a_rise;
        fwd = b_rise;
      end
      cpd_pkg::FMT_QX1: begin
        fwd = a_rise & ~b_eff;
        rev = a_rise & b_eff;
      end
      cpd_pkg::FMT_QX2: begin
        fwd = (a_rise & ~b_eff) | (a_fall & b_eff);
        rev = (a_rise & b_eff) | (a_fall & ~b_eff);
      end
      cpd_pkg::FMT_QX4: begin
        // Both phases moving at once has no defined sense: skipped
        if (!((a_rise | a_fall) && (b_rise | b_fall))) begin
          fwd = (a_rise & ~b_eff) | (a_fall & b_eff)
              | (b_rise & a_eff) | (b_fall & ~a_eff);
          rev = (a_rise & b_eff) | (a_fall & ~b_eff)
              | (b_rise & ~a_eff) | (b_fall & a_eff);
        end
      end
      default: begin
        fwd = 1'b0;
        rev = 1'b0;
      end
    endcase
    // Invalid setting or active clear blocks every command. Just after
    // reset the stages hold reset levels, not pin levels, so a pin idling
    // high would look like an edge: pins count from the fourth edge on
    if (!mode.valid || clear_active_r || !live_r[2]) begin
      fwd = 1'b0;
      rev = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    mode_nxt     = command_pulse_mode_select;
    live_nxt     = {live_r[1:0], 1'b1};
    mode_err_nxt = ~mode.valid;
    a_prev_nxt   = pins_s.a;
    b_prev_nxt   = pins_s.b;
    step_fwd_nxt = fwd;
    step_rev_nxt = rev;
    // Filter: short clear pulses are ignored, by design
    if (!pins_s.clr) begin
      clr_cnt_nxt = '0;
    end else if (clr_cnt_r == CLR_FULL) begin
      clr_cnt_nxt = clr_cnt_r;
    end else begin
      clr_cnt_nxt = clr_cnt_r + 1'b1;
    end
    clear_active_nxt = pins_s.clr
                     && (clr_cnt_r >= CLR_LAST);
    if (clear_active_r) begin
      cmd_count_nxt = '0;
    end else begin
      cmd_count_nxt = cmd_count_r
                    + CNT_W'(fwd) - CNT_W'(rev);
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_r         <= cpd_pkg::MODE_RST;
      mode_err_r     <= 1'b0;
      live_r         <= '0;
      a_prev_r       <= 1'b0;
      b_prev_r       <= 1'b0;
      step_fwd_r     <= 1'b0;
      step_rev_r     <= 1'b0;
      clr_cnt_r      <= '0;
      clear_active_r <= 1'b0;
      cmd_count_r    <= '0;
    end else begin
      mode_r         <= mode_nxt;
      mode_err_r     <= mode_err_nxt;
      live_r         <= live_nxt;
      a_prev_r       <= a_prev_nxt;
      b_prev_r       <= b_prev_nxt;
      step_fwd_r     <= step_fwd_nxt;
      step_rev_r     <= step_rev_nxt;
      clr_cnt_r      <= clr_cnt_nxt;
      clear_active_r <= clear_active_nxt;
      cmd_count_r    <= cmd_count_nxt;
    end
  end

  assign step_fwd     = step_fwd_r;
  assign step_rev     = step_rev_r;
  assign cmd_count    = cmd_count_r;
  assign clear_active = clear_active_r;
  assign mode_err     = mode_err_r;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

  sequence s_clr_held;
    pins_s.clr && clr_cnt_r == CLR_LAST;
  endsequence

  sequence s_clr_done;
    clear_active_r ##1 (cmd_count_r == '0);
  endsequence

  a_mode_range: assert property (
    mode_r > cpd_pkg::MODE_MAX |=> mode_err_r && !step_fwd_r && !step_rev_r)
    else $error("out-of-range mode not refused");

  a_pair_roles: assert property (
    mode.valid && mode.fmt == cpd_pkg::FMT_PD && !a_rise
    |=> !step_fwd_r && !step_rev_r)
    else $error("direction pair alone made a step");

  a_neg_logic: assert property (
    mode_r == 4'h5 && !clear_active_r && !pins_s.a && a_prev_r
    && !pins_s.b |=> step_fwd_r && !step_rev_r)
    else $error("negative logic feed pulse mis-decoded");

  a_pd_dir: assert property (
    mode_r == 4'h0 && !clear_active_r && a_rise
    |=> (step_fwd_r == $past(pins_s.b)) && (step_rev_r == !$past(pins_s.b)))
    else $error("pulse plus direction mis-decoded");

  a_sep_pulse: assert property (
    mode.valid && mode.fmt == cpd_pkg::FMT_SEP && !clear_active_r
    |=> step_rev_r == $past(a_rise) && step_fwd_r == $past(b_rise))
    else $error("separate pulse roles wrong");

  a_quad_x4: assert property (
    mode.valid && mode.fmt == cpd_pkg::FMT_QX4 && !clear_active_r
    && b_rise && !a_rise && !a_fall |=> step_fwd_r == $past(a_eff))
    else $error("x4 phase B edge not counted");

  a_quad_x1: assert property (
    mode.valid && mode.fmt == cpd_pkg::FMT_QX1 && !clear_active_r
    && a_rise |=> step_fwd_r != step_rev_r
    && step_rev_r == $past(b_eff))
    else $error("x1 sense wrong");

  a_clear_seq: assert property (
    s_clr_held |=> s_clr_done)
    else $error("held clear did not zero count");

  a_clear_off: assert property (
    clear_active_r |=> !step_fwd_r && !step_rev_r)
    else $error("step issued while clear active");

endmodule : cpd_decoder

`default_nettype wire

//--- test/cpd_ctrl_model.sv
// Motion controller model that drives the command pulse and clear pins
`default_nettype none

module cpd_ctrl_model (
  // Clock
  input  wire logic sys_clk,
  // Command pins
  output logic      cmd_a,
  output logic      cmd_b,
  output logic      clr
);
  timeunit 1ns;
  timeprecision 1ps;

  // Half period of 100 cycles keeps the rate at 250 kpps or below
  int         gap = 100;
  logic       neg = 1'b0;
  logic [1:0] ph  = 2'h0;

  initial begin
    cmd_a = 1'b0;
    cmd_b = 1'b0;
    clr   = 1'b0;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc

  // Same timing whatever the polarity, only the levels turn over
  task automatic idle(input logic n);
    neg   = n;
    ph    = 2'h0;
    cmd_a = n;
    cmd_b = n;
    cyc(gap);
  endtask : idle

  // Direction set up a half period ahead of the feed pulse
  task automatic pd_step(input logic fwd);
    cmd_b = fwd ^ neg;
    cyc(gap);
    cmd_a = ~neg;
    cyc(gap);
    cmd_a = neg;
    cyc(gap);
  endtask : pd_step

  // Reverse pulses on pair A, forward pulses on pair B
  task automatic sep_step(input logic fwd);
    if (fwd) cmd_b = ~neg;
    else cmd_a = ~neg;
    cyc(gap);
    cmd_a = neg;
    cmd_b = neg;
    cyc(gap);
  endtask : sep_step

  // One whole input cycle; A leads B when forward
  task automatic quad_cycle(input logic fwd);
    repeat (4) begin
      ph    = fwd ? ph + 2'h1 : ph - 2'h1;
      cmd_a = (ph == 2'h1 || ph == 2'h2) ^ neg;
      cmd_b = ph[1] ^ neg;
      cyc(gap / 2);
    end
  endtask : quad_cycle

  // Clear held for n cycles; under 1000 it is too short to take
  task automatic clear_hold(input int n);
    clr = 1'b1;
    cyc(n);
    clr = 1'b0;
    cyc(gap);
  endtask : clear_hold

endmodule : cpd_ctrl_model

`default_nettype wire

//--- test/test_command_pulse_input_decoder.sv
// Self-checking bench for the command pulse input decoder
`default_nettype none

module test_command_pulse_input_decoder;
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------------
  // Hookup
  // ------------------------------------------------------------------
  logic                        sys_clk;
  logic                        arst_n;
  logic                        cmd_a;
  logic                        cmd_b;
  logic                        clr;
  logic [cpd_pkg::MODE_W-1:0]  mode;
  logic                        step_fwd;
  logic                        step_rev;
  logic                        clear_active;
  logic                        mode_err;
  logic [15:0]                 cmd_count;
  logic [15:0]                 n_fwd;
  logic [15:0]                 n_rev;
  int                          n_mismatch = 0;
  int                          compares   = 0;

  cpd_decoder #(.CNT_W(16)) i_dut (
    .sys_clk                   (sys_clk),
    .arst_n                    (arst_n),
    .cmd_a_in                  (cmd_a),
    .cmd_b_in                  (cmd_b),
    .deviation_clear_in        (clr),
    .command_pulse_mode_select (mode),
    .step_fwd                  (step_fwd),
    .step_rev                  (step_rev),
    .cmd_count                 (cmd_count),
    .clear_active              (clear_active),
    .mode_err                  (mode_err)
  );

  cpd_ctrl_model i_ctrl (
    .sys_clk (sys_clk),
    .cmd_a   (cmd_a),
    .cmd_b   (cmd_b),
    .clr     (clr)
  );

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // Step pulses last one cycle, so tally them as they come
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      n_fwd <= 16'h0000;
      n_rev <= 16'h0000;
    end else begin
      if (step_fwd === 1'b1) n_fwd <= n_fwd + 16'h0001;
      if (step_rev === 1'b1) n_rev <= n_rev + 16'h0001;
    end
  end

  // ------------------------------------------------------------------
  // Checks and closing
  // ------------------------------------------------------------------
  task automatic chk_w(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_w

  task automatic chk_b(input logic got, input logic exp, input string what);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask : chk_b

  task automatic close_out;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic unit(input int f, input logic fwd);
    if (f == 0) i_ctrl.pd_step(fwd);
    else if (f == 1) i_ctrl.sep_step(fwd);
    else i_ctrl.quad_cycle(fwd);
  endtask : unit

  task automatic t_reset;
    i_ctrl.cyc(3);
    chk_w(cmd_count, 16'h0000, "count after reset");
    chk_b(clear_active, 1'b0, "clear after reset");
    chk_b(mode_err, 1'b0, "mode_err after reset");
    $display("t_reset done");
  endtask : t_reset

  // Every valid setting: four units forward then four back; mode 0 runs slow
  task automatic t_modes;
    logic [15:0] f0, r0, c0, k;
    for (int m = 0; m <= 9; m++) begin
      mode = m[3:0];
      i_ctrl.gap = (m == 0) ? 200 : 100;
      i_ctrl.idle(m >= 5);
      k  = (m % 5 == 3) ? 16'h0002 : (m % 5 == 4) ? 16'h0004 : 16'h0001;
      f0 = n_fwd;
      r0 = n_rev;
      c0 = cmd_count;
      repeat (4) unit(m % 5, 1'b1);
      chk_w(n_fwd - f0, k * 16'h0004, "fwd steps");
      chk_w(cmd_count - c0, k * 16'h0004, "count fwd");
      repeat (4) unit(m % 5, 1'b0);
      chk_w(n_rev - r0, k * 16'h0004, "rev steps");
      chk_w(cmd_count, c0, "count net");
    end
    $display("t_modes done");
  endtask : t_modes

  // Settings above nine are refused and give no steps
  task automatic t_mode_err;
    logic [15:0] f0, c0;
    for (int m = 10; m <= 15; m++) begin
      mode = m[3:0];
      i_ctrl.idle(1'b0);
      chk_b(mode_err, 1'b1, "mode_err set");
    end
    f0 = n_fwd;
    c0 = cmd_count;
    i_ctrl.pd_step(1'b1);
    chk_w(n_fwd - f0, 16'h0000, "steps in bad mode");
    chk_w(cmd_count, c0, "count in bad mode");
    mode = 4'h0;
    i_ctrl.idle(1'b0);
    chk_b(mode_err, 1'b0, "mode_err clear");
    $display("t_mode_err done");
  endtask : t_mode_err

  // Short clear ignored; a long one zeroes the count and blocks pulses
  task automatic t_clear;
    logic [15:0] f0, c0;
    i_ctrl.pd_step(1'b1);
    c0 = cmd_count;
    i_ctrl.clear_hold(900);
    chk_b(clear_active, 1'b0, "short clear");
    chk_w(cmd_count, c0, "count after short clear");
    i_ctrl.clr = 1'b1;
    i_ctrl.cyc(990);
    chk_b(clear_active, 1'b0, "clear early");
    i_ctrl.cyc(20);
    chk_b(clear_active, 1'b1, "clear taken");
    chk_w(cmd_count, 16'h0000, "count cleared");
    f0 = n_fwd;
    i_ctrl.pd_step(1'b1);
    chk_w(n_fwd - f0, 16'h0000, "steps under clear");
    chk_w(cmd_count, 16'h0000, "count under clear");
    i_ctrl.clr = 1'b0;
    i_ctrl.cyc(10);
    chk_b(clear_active, 1'b0, "clear released");
    i_ctrl.pd_step(1'b1);
    chk_w(cmd_count, 16'h0001, "count resumes");
    $display("t_clear done");
  endtask : t_clear

  // Reset in mid-run while negative x2 pins idle high: no false count
  task automatic t_reset_mid;
    mode = 4'h8;
    i_ctrl.idle(1'b1);
    arst_n = 1'b0;
    i_ctrl.cyc(5);
    arst_n = 1'b1;
    i_ctrl.cyc(10);
    chk_w(cmd_count, 16'h0000, "count after mid reset");
    chk_w(n_fwd + n_rev, 16'h0000, "steps after mid reset");
    i_ctrl.quad_cycle(1'b1);
    chk_w(n_fwd, 16'h0002, "x2 steps after mid reset");
    chk_w(cmd_count, 16'h0002, "count after mid reset run");
    $display("t_reset_mid done");
  endtask : t_reset_mid

  // ------------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    mode   = 4'h0;
    repeat (20) @(posedge sys_clk);
    #1;
    arst_n = 1'b1;
    t_reset;
    t_modes;
    t_mode_err;
    t_clear;
    t_reset_mid;
    close_out;
  end

  // About three times the expected run of some 25k cycles
  initial begin
    #1_500_000;
    n_mismatch++;
    $display("[FAIL] %0t watchdog expired", $time);
    close_out;
  end

endmodule : test_command_pulse_input_decoder

`default_nettype wire
